//--- core/cpu_instruction_decoder.sv
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "cpu_decoder_map.svh"

module cpu_instruction_decoder
  import cpu_decoder_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic MEM_REQ_O,
  output logic [ADDR_W-1:0] MEM_ADDR_O,
  input wire logic MEM_ACK_I,
  input wire logic [7:0] MEM_RDATA_I,
  output logic DECODE_DONE_O
);

  // the operand and pc registers are sixteen bits, so wider buses cannot be served
  if (ADDR_W < 8 || ADDR_W > 16) begin : g_bad_addr_w
    $error("ADDR_W must lie between 8 and 16");
  end

  // opcode classifier: fixed opcodes sit above the groups they overlap
  function automatic decode_t decode_op(input logic [7:0] op);
    decode_t d;
    d.cls = CL_UNKNOWN;
    d.len = 2'h1;
    d.cyc = 3'h1;
    d.memop = 1'b0;
    casez (op)
      `OP_IN: begin
        d.cls = CL_PORT_IN;
        d.len = 2'h2;
        d.cyc = 3'h3;
      end
      `OP_OUT: begin
        d.cls = CL_PORT_OUT;
        d.len = 2'h2;
        d.cyc = 3'h3;
      end
      `OP_INT_EN: d.cls = CL_INT_ENABLE;
      `OP_INT_MASK: d.cls = CL_INT_MASK;
      `OP_HALT: d.cls = CL_HALT;
      `OP_CARRY_FLIP: d.cls = CL_CARRY_FLIP;
      `OP_CARRY_SET: d.cls = CL_CARRY_SET;
      `OP_NOP: d.cls = CL_NO_OPERATION;
      `OP_SWAP_DE: d.cls = CL_SWAP_DE_HL;
      `OP_SWAP_TOP: begin
        d.cls = CL_SWAP_TOP_HL;
        d.cyc = 3'h5;
      end
      `OP_SP_FROM_HL: d.cls = CL_SP_FROM_HL;
      `OP_JUMP_PAIR: d.cls = CL_JUMP_PAIR;
      `OP_JUMP: begin
        d.cls = CL_JUMP;
        d.len = 2'h3;
        d.cyc = 3'h3;
      end
      `PAT_RESTART: begin
        d.cls = CL_RESTART;
        d.cyc = 3'h3;
      end
      `PAT_INC: begin
        d.cls = CL_REG_INC;
        d.cyc = 3'h3;
        d.memop = (op[5:3] == `SEL_MEMORY);
      end
      `PAT_DEC: begin
        d.cls = CL_REG_DEC;
        d.cyc = 3'h3;
        d.memop = (op[5:3] == `SEL_MEMORY);
      end
      `PAT_PUSH: begin
        d.cls = CL_PUSH;
        d.cyc = 3'h3;
      end
      `PAT_POP: begin
        d.cls = CL_POP;
        d.cyc = 3'h3;
      end
      `PAT_PAIR_ADD: begin
        d.cls = CL_PAIR_ADD;
        d.cyc = 3'h3;
      end
      `PAT_PAIR_INC: d.cls = CL_PAIR_INC;
      `PAT_PAIR_DEC: d.cls = CL_PAIR_DEC;
      `PAT_ROTATE: d.cls = CL_ROTATE;
      `PAT_COPY: begin
        // memory on either side costs the extra cycle
        d.cls = CL_REG_COPY;
        d.memop = (op[5:3] == `SEL_MEMORY) || (op[2:0] == `SEL_MEMORY);
        d.cyc = d.memop ? 3'h2 : 3'h1;
      end
      `PAT_ACC_IND: begin
        // bit 4 picks BC or DE, bit 3 splits store from load
        d.cls = op[3] ? CL_LOAD_IND : CL_STORE_IND;
        d.cyc = 3'h2;
      end
      `PAT_ALU_REG: begin
        d.cls = CL_ALU_REG;
        d.memop = (op[2:0] == `SEL_MEMORY);
      end
      `PAT_DIRECT: begin
        d.len = 2'h3;
        d.cyc = op[4] ? 3'h4 : 3'h5;
        case (op[4:3])
          2'h0: d.cls = CL_STORE_PAIR_DIR;
          2'h1: d.cls = CL_LOAD_PAIR_DIR;
          2'h2: d.cls = CL_STORE_ACC_DIR;
          default: d.cls = CL_LOAD_ACC_DIR;
        endcase
      end
      `PAT_PAIR_IMM: begin
        d.cls = CL_PAIR_LOAD_IMM;
        d.len = 2'h3;
        d.cyc = 3'h3;
      end
      `PAT_REG_IMM: begin
        d.cls = CL_REG_LOAD_IMM;
        d.len = 2'h2;
        d.memop = (op[5:3] == `SEL_MEMORY);
        d.cyc = d.memop ? 3'h3 : 3'h2;
      end
      `PAT_ALU_IMM: begin
        d.cls = CL_ALU_IMM;
        d.len = 2'h2;
        d.cyc = 3'h2;
      end
      `PAT_JUMP_COND: begin
        d.cls = CL_JUMP_COND;
        d.len = 2'h3;
        d.cyc = 3'h3;
      end
      default: d.cls = CL_UNKNOWN;
    endcase
    return d;
  endfunction : decode_op

  fetch_state_t state_q;
  logic [15:0] pc_q;
  logic [3:0] flags_q;
  logic [15:0] hl_q;
  logic [7:0] opcode_q;
  logic [15:0] operand_q;
  decode_t dec_q;
  decode_t dec_now;
  logic taken_q;
  logic [15:0] eff_addr_q;
  logic mem_req_q;
  logic [ADDR_W-1:0] mem_addr_q;
  logic done_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_en;
  logic start;
  logic cond_met;
  logic flag_pick;
  logic [15:0] seq_pc;
  logic [15:0] next_pc;
  logic [15:0] eff_addr;
  logic byte_in;

  assign dec_now = decode_op(MEM_RDATA_I);
  assign byte_in = mem_req_q && MEM_ACK_I;

  // writes land only on the access edge, when pready is already high
  assign wr_en = PSEL_I && PENABLE_I && PWRITE_I && pready_q;
  assign start = wr_en && (PADDR_I == `REG_CTRL) && PWDATA_I[`CTRL_START_BIT]
                 && (state_q == ST_IDLE);

  // apb answer: one wait-free access phase, read data prepared in setup
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= PSEL_I && !PENABLE_I;
      if (PSEL_I && !PENABLE_I) begin
        prdata_q <= PWRITE_I ? 32'h0000_0000 : rd_word;
        pslverr_q <= !rd_hit;
      end else begin
        prdata_q <= 32'h0000_0000;
        pslverr_q <= 1'b0;
      end
    end
  end

  // read mux; unmapped addresses read zero and flag an error
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (PADDR_I)
      `REG_CTRL: rd_word[`CTRL_BUSY_BIT] = (state_q != ST_IDLE);
      `REG_PC: rd_word[15:0] = pc_q;
      `REG_FLAGS: rd_word[3:0] = flags_q;
      `REG_HL: rd_word[15:0] = hl_q;
      `REG_OPINFO: begin
        rd_word[7:0] = opcode_q;
        rd_word[`OPINFO_LEN_LSB +: 2] = dec_q.len;
        rd_word[`OPINFO_CYC_LSB +: 3] = dec_q.cyc;
      end
      `REG_OPERAND: begin
        rd_word[15:0] = operand_q;
        rd_word[`OPERAND_ADDR_LSB +: 16] = eff_addr_q;
      end
      `REG_FIELDS: begin
        rd_word[5:0] = dec_q.cls;
        rd_word[`FIELDS_MEMOP_BIT] = dec_q.memop;
        rd_word[`FIELDS_TAKEN_BIT] = taken_q;
        rd_word[`FIELDS_PAIR_LSB +: 2] = opcode_q[5:4];
        rd_word[`FIELDS_SP_BIT] = (opcode_q[5:4] == `PAIR_SP);
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // software-held context: flags and HL may change at any time
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      flags_q <= 4'h0;
      hl_q <= 16'h0000;
    end else if (wr_en) begin
      if (PADDR_I == `REG_FLAGS) begin
        flags_q <= PWDATA_I[3:0];
      end
      if (PADDR_I == `REG_HL) begin
        hl_q <= PWDATA_I[15:0];
      end
    end
  end

  // condition field: bits 5:4 pick the flag, bit 3 the sense wanted
  always_comb begin
    case (opcode_q[5:4])
      2'h0: flag_pick = flags_q[`FLAG_ZERO_BIT];
      2'h1: flag_pick = flags_q[`FLAG_CARRY_BIT];
      2'h2: flag_pick = flags_q[`FLAG_PARITY_BIT];
      default: flag_pick = flags_q[`FLAG_SIGN_BIT];
    endcase
    cond_met = (flag_pick == opcode_q[3]);
  end

  // next pc and operand address, valid in the resolve state
  always_comb begin
    seq_pc = 16'(mem_addr_q) + 16'h0001;
    next_pc = seq_pc;
    if (dec_q.cls == CL_JUMP || (dec_q.cls == CL_JUMP_COND && cond_met)) begin
      next_pc = operand_q;
    end else if (dec_q.cls == CL_JUMP_PAIR) begin
      next_pc = hl_q;
    end
    eff_addr = 16'h0000;
    if (dec_q.memop) begin
      eff_addr = hl_q;
    end else if (dec_q.cls inside {CL_STORE_ACC_DIR, CL_LOAD_ACC_DIR,
                                   CL_STORE_PAIR_DIR, CL_LOAD_PAIR_DIR}) begin
      eff_addr = operand_q;
    end
  end

  // fetch sequencer: opcode, then low byte, then high byte
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: if (start) begin
          state_q <= ST_OPCODE;
        end
        ST_OPCODE: if (byte_in) begin
          state_q <= (dec_now.len == 2'h1) ? ST_RESOLVE : ST_LOW;
        end
        ST_LOW: if (byte_in) begin
          state_q <= (dec_q.len == 2'h3) ? ST_HIGH : ST_RESOLVE;
        end
        ST_HIGH: if (byte_in) begin
          state_q <= ST_RESOLVE;
        end
        ST_RESOLVE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // memory request: held until acknowledged, addresses climb by one
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      mem_req_q <= 1'b0;
      mem_addr_q <= '0;
    end else if (start) begin
      mem_req_q <= 1'b1;
      mem_addr_q <= pc_q[ADDR_W-1:0];
    end else if (byte_in) begin
      if ((state_q == ST_OPCODE && dec_now.len != 2'h1)
          || (state_q == ST_LOW && dec_q.len == 2'h3)) begin
        mem_addr_q <= mem_addr_q + ADDR_W'(1);
      end else begin
        mem_req_q <= 1'b0;
      end
    end
  end

  // captured instruction bytes and their decode
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      opcode_q <= 8'h00;
      operand_q <= 16'h0000;
      dec_q <= '0;
    end else if (byte_in) begin
      case (state_q)
        ST_OPCODE: begin
          opcode_q <= MEM_RDATA_I;
          dec_q <= dec_now;
          operand_q <= 16'h0000;
        end
        ST_LOW: operand_q[7:0] <= MEM_RDATA_I;
        ST_HIGH: operand_q[15:8] <= MEM_RDATA_I;
        default: operand_q <= operand_q;
      endcase
    end
  end

  // pc: software may move it only while idle, resolve advances it
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pc_q <= `PC_RESET;
    end else if (state_q == ST_RESOLVE) begin
      pc_q <= next_pc;
    end else if (wr_en && PADDR_I == `REG_PC && state_q == ST_IDLE) begin
      pc_q <= PWDATA_I[15:0];
    end
  end

  // results and completion pulse
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      taken_q <= 1'b0;
      eff_addr_q <= 16'h0000;
      done_q <= 1'b0;
    end else begin
      done_q <= (state_q == ST_RESOLVE);
      if (state_q == ST_RESOLVE) begin
        taken_q <= (dec_q.cls == CL_JUMP) || (dec_q.cls == CL_JUMP_PAIR)
                   || (dec_q.cls == CL_JUMP_COND && cond_met);
        eff_addr_q <= eff_addr;
      end
    end
  end

  assign PRDATA_O = prdata_q;
  assign PREADY_O = pready_q;
  assign PSLVERR_O = pslverr_q;
  assign MEM_REQ_O = mem_req_q;
  assign MEM_ADDR_O = mem_addr_q;
  assign DECODE_DONE_O = done_q;

endmodule : cpu_instruction_decoder

//--- common/cpu_decoder_map.svh
`ifndef CPU_DECODER_MAP_SVH
`define CPU_DECODER_MAP_SVH
// How it works
// - register selector 000..111: B C D E H L memory A
// - pair selector: BC, DE, HL, stack_pointer
// - port in/out: two bytes, three cycles
// - interrupt enable, mask, halt: one byte, one cycle
// - restart 11 exp 111: one byte, three cycles
// - carry flip and carry set: one byte, one cycle
// - all-zero byte is no_operation, one cycle
// - register increment/decrement: one byte, three cycles
// - stack push/pop of a pair: three cycles
// - pair add to HL: one byte, three cycles
// - pair increment/decrement: one byte, one cycle
// - swaps and stack pointer load from HL
// - four accumulator rotates: one byte, one cycle
// - register copy: one cycle, two with memory
// - indirect accumulator store/load via BC or DE
// - register ALU ops, eight kinds, one cycle
// - direct addressing: three bytes, four or five cycles
// - pair load immediate: three bytes, three cycles
// - register load immediate: two or three cycles
// - immediate ALU ops: two bytes, two cycles
// - jumps: three bytes, three cycles, eight conditions
// - jump to HL: one byte, one cycle
// - carry jump taken on 1, no-carry on 0
// - minus jump on sign 1, plus on 0

// register byte addresses
`define REG_CTRL 8'h00
`define REG_PC 8'h04
`define REG_FLAGS 8'h08
`define REG_HL 8'h0C
`define REG_OPINFO 8'h10
`define REG_OPERAND 8'h14
`define REG_FIELDS 8'h18

// field positions
`define CTRL_START_BIT 0
`define CTRL_BUSY_BIT 1
`define FLAG_ZERO_BIT 0
`define FLAG_CARRY_BIT 1
`define FLAG_PARITY_BIT 2
`define FLAG_SIGN_BIT 3
`define OPINFO_LEN_LSB 8
`define OPINFO_CYC_LSB 12
`define FIELDS_MEMOP_BIT 8
`define FIELDS_TAKEN_BIT 9
`define FIELDS_PAIR_LSB 10
`define FIELDS_SP_BIT 12
`define OPERAND_ADDR_LSB 16

// reset values and selector codes
`define PC_RESET 16'h0000
`define SEL_MEMORY 3'h6
`define PAIR_SP 2'h3

// fixed opcodes and opcode groups
`define OP_IN 8'hDB
`define OP_OUT 8'hD3
`define OP_INT_EN 8'hFB
`define OP_INT_MASK 8'hF3
`define OP_HALT 8'h76
`define OP_CARRY_FLIP 8'h3F
`define OP_CARRY_SET 8'h37
`define OP_NOP 8'h00
`define OP_SWAP_DE 8'hEB
`define OP_SWAP_TOP 8'hE3
`define OP_SP_FROM_HL 8'hF9
`define OP_JUMP_PAIR 8'hE9
`define OP_JUMP 8'hC3
`define PAT_INC 8'b00???100
`define PAT_DEC 8'b00???101
`define PAT_PUSH 8'b11??0101
`define PAT_POP 8'b11??0001
`define PAT_PAIR_ADD 8'b00??1001
`define PAT_PAIR_INC 8'b00??0011
`define PAT_PAIR_DEC 8'b00??1011
`define PAT_ROTATE 8'b000??111
`define PAT_COPY 8'b01??????
`define PAT_ACC_IND 8'b000??010
`define PAT_ALU_REG 8'b10??????
`define PAT_DIRECT 8'b001??010
`define PAT_PAIR_IMM 8'b00??0001
`define PAT_REG_IMM 8'b00???110
`define PAT_ALU_IMM 8'b11???110
`define PAT_JUMP_COND 8'b11???010
`define PAT_RESTART 8'b11???111
`endif

//--- common/cpu_decoder_pkg.sv
package cpu_decoder_pkg;
  typedef enum logic [5:0] {
    CL_UNKNOWN, CL_PORT_IN, CL_PORT_OUT, CL_INT_ENABLE, CL_INT_MASK, CL_HALT,
    CL_RESTART, CL_CARRY_FLIP, CL_CARRY_SET, CL_NO_OPERATION, CL_REG_INC,
    CL_REG_DEC, CL_PUSH, CL_POP, CL_PAIR_ADD, CL_PAIR_INC, CL_PAIR_DEC,
    CL_SWAP_DE_HL, CL_SWAP_TOP_HL, CL_SP_FROM_HL, CL_ROTATE, CL_REG_COPY,
    CL_STORE_IND, CL_LOAD_IND, CL_ALU_REG, CL_STORE_ACC_DIR, CL_LOAD_ACC_DIR,
    CL_STORE_PAIR_DIR, CL_LOAD_PAIR_DIR, CL_PAIR_LOAD_IMM, CL_REG_LOAD_IMM,
    CL_ALU_IMM, CL_JUMP_PAIR, CL_JUMP, CL_JUMP_COND
  } op_class_t;

  typedef struct packed {
    op_class_t cls;
    logic [1:0] len;
    logic [2:0] cyc;
    logic memop;
  } decode_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_OPCODE, ST_LOW, ST_HIGH, ST_RESOLVE
  } fetch_state_t;
endpackage : cpu_decoder_pkg

//--- verif/fetch_memory_model.sv
`timescale 1ns/1ps
module fetch_memory_model #(
  parameter int ADDR_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire logic [ADDR_W-1:0] addr_i,
  output logic ack_o,
  output logic [7:0] rdata_o
);
  logic [7:0] mem_q [256];
  int wait_n = 0;
  int cnt_q;
  // answer after wait_n cycles; idle data toggles so a stale byte never looks valid
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_o <= 1'b0;
      rdata_o <= 8'h00;
      cnt_q <= 0;
    end else if (req_i && !ack_o && cnt_q >= wait_n) begin
      ack_o <= 1'b1;
      rdata_o <= mem_q[addr_i[7:0]];
      cnt_q <= 0;
    end else begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      cnt_q <= req_i ? cnt_q + 1 : 0;
    end
  end
endmodule : fetch_memory_model

//--- verif/cpu_instruction_decoder_properties.sv
`timescale 1ns/1ps
module cpu_decoder_checker
  import cpu_decoder_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic MEM_REQ_O,
  input wire logic [ADDR_W-1:0] MEM_ADDR_O,
  input wire logic MEM_ACK_I,
  input wire logic [7:0] MEM_RDATA_I,
  input wire logic DECODE_DONE_O
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);
  logic setup;
  // setup phase of an apb transfer
  assign setup = PSEL_I && !PENABLE_I;
  pready_after_setup_a: assert property (setup |=> PREADY_O)
    else $error("no ready after setup");
  pready_single_a: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready longer than one cycle");
  err_unmapped_a: assert property (setup && PADDR_I > 8'h18 |=> PSLVERR_O)
    else $error("unmapped address not refused");
  err_mapped_a: assert property (setup && PADDR_I <= 8'h18 && PADDR_I[1:0] == 2'h0
    |=> !PSLVERR_O) else $error("mapped address refused");
  rdata_idle_a: assert property (!PREADY_O |-> PRDATA_O == 32'h0)
    else $error("read data outside access");
  err_zero_a: assert property (PSLVERR_O |-> PREADY_O && PRDATA_O == 32'h0)
    else $error("error without ready or with data");
  req_hold_a: assert property (MEM_REQ_O && !MEM_ACK_I |=> MEM_REQ_O && $stable(MEM_ADDR_O))
    else $error("fetch request dropped or moved");
  addr_step_a: assert property ((MEM_REQ_O && MEM_ACK_I ##1 MEM_REQ_O)
    |-> MEM_ADDR_O == $past(MEM_ADDR_O) + 1'b1) else $error("fetch address skipped");
  done_single_a: assert property (DECODE_DONE_O |=> !DECODE_DONE_O)
    else $error("done longer than one cycle");
  done_after_fetch_a: assert property (DECODE_DONE_O |-> !MEM_REQ_O
    && $past(MEM_REQ_O && MEM_ACK_I, 2)) else $error("done not two cycles after last byte");
  // main scenarios reached
  cover property (PSLVERR_O);
  cover property (MEM_REQ_O && !MEM_ACK_I ##1 MEM_REQ_O && !MEM_ACK_I);
  cover property (DECODE_DONE_O);
endmodule : cpu_decoder_checker

bind cpu_instruction_decoder cpu_decoder_checker #(.ADDR_W(ADDR_W)) u_cpu_decoder_checker (
  .SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
  .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .MEM_REQ_O(MEM_REQ_O),
  .MEM_ADDR_O(MEM_ADDR_O), .MEM_ACK_I(MEM_ACK_I), .MEM_RDATA_I(MEM_RDATA_I),
  .DECODE_DONE_O(DECODE_DONE_O));

//--- verif/cpu_instruction_decoder_tb.sv
`timescale 1ns/1ps
`include "cpu_decoder_map.svh"
module cpu_instruction_decoder_tb;
  import cpu_decoder_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, req, ack, done, last_err;
  logic [15:0] maddr;
  logic [7:0] mdata;
  int fail_count = 0;
  int samples_checked = 0;
  always #5 clk = ~clk;
  cpu_instruction_decoder u_cpu_instruction_decoder (
    .SYS_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .MEM_REQ_O(req), .MEM_ADDR_O(maddr), .MEM_ACK_I(ack),
    .MEM_RDATA_I(mdata), .DECODE_DONE_O(done));
  fetch_memory_model u_fetch_memory_model (.clk_i(clk), .rst_n_i(rst_n), .req_i(req),
    .addr_i(maddr), .ack_o(ack), .rdata_o(mdata));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; request held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
    int n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    r = prdata;
    last_err = pslverr;
    chk(pready, 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so the next call never re-drives psel in this time step
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    apb(1'b0, a, 32'h0, r);
  endtask : rd
  // place an instruction at pc, start decoding and wait for done
  task automatic run(input logic [15:0] pc, input logic [7:0] op, input logic [7:0] b2,
      input logic [7:0] b3);
    int n = 0;
    u_fetch_memory_model.mem_q[pc[7:0]] = op;
    u_fetch_memory_model.mem_q[pc[7:0] + 8'h01] = b2;
    u_fetch_memory_model.mem_q[pc[7:0] + 8'h02] = b3;
    wr(`REG_PC, {16'h0, pc});
    wr(`REG_CTRL, 32'h1);
    while (done !== 1'b1 && n < 300) begin
      n++;
      @(posedge clk);
    end
    chk(done, 1'b1);
  endtask : run
  task automatic one(input logic [7:0] op, input logic [1:0] len, input logic [2:0] cyc,
      input op_class_t cls);
    logic [31:0] r;
    run(16'h0040, op, 8'h34, 8'h12);
    rd(`REG_OPINFO, r);
    chk({r[14:12], r[9:8], r[7:0]}, {cyc, len, op});
    rd(`REG_FIELDS, r);
    chk(r[5:0], cls);
  endtask : one
  task automatic t_apb;
    logic [31:0] r;
    rd(`REG_PC, r);
    chk(r, 32'h0);
    wr(`REG_HL, 32'h0000_5A3C);
    rd(`REG_HL, r);
    chk(r, 32'h0000_5A3C);
    rd(8'h1C, r);
    chk(last_err, 1'b1);
    chk(r, 32'h0);
    wr(8'h40, 32'h1);
    chk(last_err, 1'b1);
  endtask : t_apb
  task automatic t_table;
    one(`OP_IN, 2'h2, 3'h3, CL_PORT_IN);
    one(`OP_OUT, 2'h2, 3'h3, CL_PORT_OUT);
    one(8'hFB, 2'h1, 3'h1, CL_INT_ENABLE);
    one(8'hF3, 2'h1, 3'h1, CL_INT_MASK);
    one(8'h76, 2'h1, 3'h1, CL_HALT);
    one(8'h3F, 2'h1, 3'h1, CL_CARRY_FLIP);
    one(8'h37, 2'h1, 3'h1, CL_CARRY_SET);
    one(8'h00, 2'h1, 3'h1, CL_NO_OPERATION);
    one(8'hEB, 2'h1, 3'h1, CL_SWAP_DE_HL);
    one(8'hE3, 2'h1, 3'h5, CL_SWAP_TOP_HL);
    one(8'hF9, 2'h1, 3'h1, CL_SP_FROM_HL);
    one(8'h41, 2'h1, 3'h1, CL_REG_COPY);
    one(8'h46, 2'h1, 3'h2, CL_REG_COPY);
    one(8'h70, 2'h1, 3'h2, CL_REG_COPY);
    one(8'h02, 2'h1, 3'h2, CL_STORE_IND);
    one(8'h1A, 2'h1, 3'h2, CL_LOAD_IND);
    one(8'h32, 2'h3, 3'h4, CL_STORE_ACC_DIR);
    one(8'h3A, 2'h3, 3'h4, CL_LOAD_ACC_DIR);
    one(8'h22, 2'h3, 3'h5, CL_STORE_PAIR_DIR);
    one(8'h2A, 2'h3, 3'h5, CL_LOAD_PAIR_DIR);
    one(8'hE9, 2'h1, 3'h1, CL_JUMP_PAIR);
    one(8'hC3, 2'h3, 3'h3, CL_JUMP);
    one(8'hDA, 2'h3, 3'h3, CL_JUMP_COND);
    one(8'hCD, 2'h1, 3'h1, CL_UNKNOWN);
    for (int k = 0; k < 8; k++) begin
      one(8'h80 | 8'(k << 3), 2'h1, 3'h1, CL_ALU_REG);
      one(8'hC6 | 8'(k << 3), 2'h2, 3'h2, CL_ALU_IMM);
      one(8'hC7 | 8'(k << 3), 2'h1, 3'h3, CL_RESTART);
      one(8'h04 | 8'(k << 3), 2'h1, 3'h3, CL_REG_INC);
      one(8'h05 | 8'(k << 3), 2'h1, 3'h3, CL_REG_DEC);
      one(8'h06 | 8'(k << 3), 2'h2, (k == 6) ? 3'h3 : 3'h2, CL_REG_LOAD_IMM);
    end
    for (int k = 0; k < 4; k++) begin
      one(8'h07 | 8'(k << 3), 2'h1, 3'h1, CL_ROTATE);
      one(8'hC5 | 8'(k << 4), 2'h1, 3'h3, CL_PUSH);
      one(8'hC1 | 8'(k << 4), 2'h1, 3'h3, CL_POP);
      one(8'h09 | 8'(k << 4), 2'h1, 3'h3, CL_PAIR_ADD);
      one(8'h03 | 8'(k << 4), 2'h1, 3'h1, CL_PAIR_INC);
      one(8'h0B | 8'(k << 4), 2'h1, 3'h1, CL_PAIR_DEC);
      one(8'h01 | 8'(k << 4), 2'h3, 3'h3, CL_PAIR_LOAD_IMM);
    end
  endtask : t_table
  task automatic t_fields;
    logic [31:0] r;
    wr(`REG_HL, 32'h0000_ABCD);
    run(16'h0040, 8'h46, 8'h00, 8'h00);
    rd(`REG_OPERAND, r);
    chk(r[31:16], 16'hABCD);
    rd(`REG_FIELDS, r);
    chk(r[8], 1'b1);
    run(16'h0040, 8'h7D, 8'h00, 8'h00);
    rd(`REG_FIELDS, r);
    chk(r[8], 1'b0);
    run(16'h0040, 8'h31, 8'h34, 8'h12);
    rd(`REG_OPERAND, r);
    chk(r[15:0], 16'h1234);
    rd(`REG_FIELDS, r);
    chk(r[12:10], 3'h7);
    run(16'h0040, 8'h11, 8'h00, 8'h00);
    rd(`REG_FIELDS, r);
    chk(r[12:10], 3'h1);
    run(16'h0040, 8'h32, 8'h78, 8'h56);
    rd(`REG_OPERAND, r);
    chk(r, 32'h5678_5678);
  endtask : t_fields
  // every condition with its flag clear and set, memory answering slowly
  task automatic t_jump;
    logic [31:0] r;
    logic tk;
    u_fetch_memory_model.wait_n = 3;
    for (int c = 0; c < 8; c++) begin
      for (int v = 0; v < 2; v++) begin
        tk = (v[0] == c[0]);
        wr(`REG_FLAGS, 32'(v) << c[2:1]);
        run(16'h0080, 8'hC2 | 8'(c << 3), 8'h34, 8'h12);
        rd(`REG_PC, r);
        chk(r[15:0], tk ? 16'h1234 : 16'h0083);
        rd(`REG_FIELDS, r);
        chk(r[9], tk);
      end
    end
    wr(`REG_HL, 32'h0000_0456);
    run(16'h0080, 8'hE9, 8'h00, 8'h00);
    rd(`REG_PC, r);
    chk(r[15:0], 16'h0456);
    u_fetch_memory_model.wait_n = 0;
  endtask : t_jump
  // a pc write while busy is dropped; slow memory keeps the fetch open
  task automatic t_busy;
    logic [31:0] r;
    int n = 0;
    u_fetch_memory_model.wait_n = 6;
    u_fetch_memory_model.mem_q[8'h60] = `OP_NOP;
    wr(`REG_PC, 32'h0000_0060);
    wr(`REG_CTRL, 32'h1);
    rd(`REG_CTRL, r);
    chk(r[`CTRL_BUSY_BIT], 1'b1);
    wr(`REG_PC, 32'h0000_0099);
    while (done !== 1'b1 && n < 300) begin
      n++;
      @(posedge clk);
    end
    chk(done, 1'b1);
    rd(`REG_PC, r);
    chk(r, 32'h0000_0061);
    rd(`REG_CTRL, r);
    chk(r[`CTRL_BUSY_BIT], 1'b0);
    u_fetch_memory_model.wait_n = 0;
  endtask : t_busy
  task automatic report_and_stop;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  // main sequence after two cycles of reset
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_apb();
    t_table();
    t_fields();
    t_jump();
    t_busy();
    report_and_stop();
  end
  // a hang is cut short well after the expected run length
  initial begin
    #500us;
    fail_count++;
    report_and_stop();
  end
endmodule : cpu_instruction_decoder_tb
